// ### rtl/spm_buf2.sv
// Small valid/ready buffer that holds transmit bytes until the link takes them.
`timescale 1ns/100ps
`default_nettype none

module spm_buf2 #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
   } spm_buf_state_type;

   spm_buf_state_type q, d;
   logic push;
   logic pop;

   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + PW'(1);
      end
      if (pop) begin
         d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + PW'(1);
      end
      case ({push, pop})
         2'b10: d.cnt = q.cnt + CW'(1);
         2'b01: d.cnt = q.cnt - CW'(1);
         default: d.cnt = q.cnt;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : spm_buf2
`default_nettype wire

// ### rtl/spm_master.sv
// Master mode serial port: control register, transmit buffer, link shifter and slave-select handling.
//
// Overview of operation
// - Setting control bit 6 places the port in master mode.
// - In master mode, a data write loads the byte into the transmit buffer.
// - When the shifter is empty and control bits 6 and 0 are both set, the buffered byte moves in and a transfer starts.
// - The byte is shifted out on MOSI most significant bit first while SCK is driven.
// - Each finished byte sets control bit 7, meaning sent and received.
// - With interrupts enabled, a set completion flag raises the interrupt request.
// - The incoming MISO byte enters the shifter most significant bit first.
// - A full received byte goes to the receive buffer, read as port data.
// - Select bits 3:2 equal to 01 (reset value) give multi-master, select pin input.
// - In multi-master with bit 6 set, a low select input clears bits 6 and 0, sets bit 5.
// - With interrupts enabled, a mode fault raises the interrupt request.
// - Select bits 00 give three-wire mode; select pin is not driven.
// - Select bit 3 set gives four-wire mode with the select pin as output.
// - In four-wire mode the select output follows select bit 2.
`timescale 1ns/100ps
`default_nettype none

module spm_master #(
   parameter int unsigned SCK_HALF = spm_pkg::SCK_HALF_DEFAULT,
   parameter int unsigned BUF_DEPTH = spm_pkg::BUF_DEPTH_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   output logic [7:0] ctrl_rdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   output logic data_wr_ready,
   output logic [7:0] data_rdata,
   input wire logic int_enable,
   output logic irq,
   output logic sck_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic select_pin_i,
   output logic select_pin_o,
   output logic select_pin_oe
);

   localparam int unsigned HW = (SCK_HALF > 1) ? $clog2(SCK_HALF) : 1;
   localparam int unsigned BW = $clog2(spm_pkg::BYTE_BITS);

   // ==========================================================================
   // State of both clock domains
   // ==========================================================================
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rx_buf;
      logic [7:0] tx_word;
      logic req;
      logic busy;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      logic sel_s1;
      logic sel_s2;
      logic irq;
   } spm_sys_state_type;

   typedef struct packed {
      spm_pkg::spm_link_state_type st;
      logic [7:0] shreg;
      logic [BW-1:0] bitcnt;
      logic [HW-1:0] halfcnt;
      logic sck;
      logic mosi;
      logic miso_s1;
      logic miso_s2;
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic en_s1;
      logic en_s2;
      logic [7:0] rx_word;
      logic rx_ok;
      logic ack;
   } spm_link_state_type_s_type;

   spm_sys_state_type s_q, s_d;
   spm_link_state_type_s_type l_q, l_d;
   logic [1:0] link_rst_q;
   logic link_rst_n;

   logic buf_out_valid;
   logic buf_out_ready;
   logic [7:0] buf_out_data;
   logic buf_in_valid;
   logic launch;
   logic enabled;
   logic [1:0] sel_mode;

   // ==========================================================================
   // Transmit buffer
   // ==========================================================================
   assign enabled = s_q.ctrl[spm_pkg::BIT_PEN] & s_q.ctrl[spm_pkg::BIT_MASTER_EN];
   assign sel_mode = s_q.ctrl[spm_pkg::BIT_SEL_HI:spm_pkg::BIT_SEL_LO];
   assign buf_in_valid = data_wr & s_q.ctrl[spm_pkg::BIT_MASTER_EN];
   assign launch = buf_out_valid & ~s_q.busy & enabled;
   assign buf_out_ready = launch;

   spm_buf2 #(
      .WIDTH(8),
      .DEPTH(BUF_DEPTH)
   ) u_txbuf (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(data_wr_ready),
      .in_data(data_wdata),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // ==========================================================================
   // System clock side
   // ==========================================================================
   always_comb begin
      s_d = s_q;
      s_d.ack_s1 = l_q.ack;
      s_d.ack_s2 = s_q.ack_s1;
      s_d.sel_s1 = select_pin_i;
      s_d.sel_s2 = s_q.sel_s1;

      // Software writes come first so that hardware events in the same cycle win.
      if (ctrl_wr) begin
         s_d.ctrl = (s_q.ctrl & ~spm_pkg::CTRL_WRITE_MASK) | (ctrl_wdata & spm_pkg::CTRL_WRITE_MASK);
      end

      // A returned byte is stable in the link flops once the acknowledge toggle arrives.
      if (s_q.ack_s2 != s_q.ack_seen) begin
         s_d.ack_seen = s_q.ack_s2;
         s_d.busy = 1'b0;
         if (l_q.rx_ok) begin
            s_d.rx_buf = l_q.rx_word;
            s_d.ctrl[spm_pkg::BIT_DONE] = 1'b1;
         end
      end

      if (launch) begin
         s_d.tx_word = buf_out_data;
         s_d.req = ~s_q.req;
         s_d.busy = 1'b1;
      end

      // Another master pulling the select pin low takes this port off the bus.
      if (sel_mode == spm_pkg::SEL_MULTI_MASTER && !s_q.sel_s2 && s_q.ctrl[spm_pkg::BIT_MASTER_EN]) begin
         s_d.ctrl[spm_pkg::BIT_MASTER_EN] = 1'b0;
         s_d.ctrl[spm_pkg::BIT_PEN] = 1'b0;
         s_d.ctrl[spm_pkg::BIT_FAULT] = 1'b1;
      end

      s_d.irq = int_enable & (s_d.ctrl[spm_pkg::BIT_DONE] | s_d.ctrl[spm_pkg::BIT_FAULT]);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl <= spm_pkg::CTRL_RESET;
         s_q.sel_s1 <= 1'b1;
         s_q.sel_s2 <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign ctrl_rdata = s_q.ctrl;
   assign data_rdata = s_q.rx_buf;
   assign irq = s_q.irq;
   assign select_pin_oe = s_q.ctrl[spm_pkg::BIT_SEL_HI];
   assign select_pin_o = s_q.ctrl[spm_pkg::BIT_SEL_HI] & s_q.ctrl[spm_pkg::BIT_SEL_LO];

   // ==========================================================================
   // Link clock side
   // ==========================================================================
   // The reset is brought into the link domain by two flops before use.
   always_ff @(posedge link_clk) begin
      link_rst_q <= {link_rst_q[0], rst_n};
   end
   assign link_rst_n = link_rst_q[1];

   always_comb begin
      l_d = l_q;
      l_d.req_s1 = s_q.req;
      l_d.req_s2 = l_q.req_s1;
      l_d.en_s1 = enabled;
      l_d.en_s2 = l_q.en_s1;
      l_d.miso_s1 = miso_i;
      l_d.miso_s2 = l_q.miso_s1;

      case (l_q.st)
         spm_pkg::SPM_LINK_IDLE: begin
            l_d.sck = 1'b0;
            if (l_q.req_s2 != l_q.req_seen) begin
               l_d.req_seen = l_q.req_s2;
               if (l_q.en_s2) begin
                  l_d.shreg = s_q.tx_word;
                  l_d.mosi = s_q.tx_word[7];
                  l_d.halfcnt = '0;
                  l_d.bitcnt = '0;
                  l_d.st = spm_pkg::SPM_LINK_SHIFT;
               end else begin
                  // A byte offered while disabled is returned without data.
                  l_d.rx_ok = 1'b0;
                  l_d.ack = ~l_q.ack;
               end
            end
         end
         spm_pkg::SPM_LINK_SHIFT: begin
            if (!l_q.en_s2) begin
               l_d.sck = 1'b0;
               l_d.rx_ok = 1'b0;
               l_d.ack = ~l_q.ack;
               l_d.st = spm_pkg::SPM_LINK_IDLE;
            end else if (l_q.halfcnt == HW'(SCK_HALF - 1)) begin
               l_d.halfcnt = '0;
               if (!l_q.sck) begin
                  l_d.sck = 1'b1;
               end else begin
                  // The slave holds MISO through the high phase; sample at its end.
                  l_d.sck = 1'b0;
                  l_d.shreg = {l_q.shreg[6:0], l_q.miso_s2};
                  if (l_q.bitcnt == BW'(spm_pkg::BYTE_BITS - 1)) begin
                     l_d.rx_word = {l_q.shreg[6:0], l_q.miso_s2};
                     l_d.rx_ok = 1'b1;
                     l_d.ack = ~l_q.ack;
                     l_d.st = spm_pkg::SPM_LINK_IDLE;
                  end else begin
                     l_d.bitcnt = l_q.bitcnt + BW'(1);
                     l_d.mosi = l_q.shreg[6];
                  end
               end
            end else begin
               l_d.halfcnt = l_q.halfcnt + HW'(1);
            end
         end
         default: begin
            l_d.sck = 1'b0;
            l_d.st = spm_pkg::SPM_LINK_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         l_q <= '0;
         l_q.st <= spm_pkg::SPM_LINK_IDLE;
      end else begin
         l_q <= l_d;
      end
   end

   assign sck_o = l_q.sck;
   assign mosi_o = l_q.mosi;

endmodule : spm_master
`default_nettype wire

// ### rtl/spm_pkg.sv
// Shared constants and types of the serial port master.
package spm_pkg;

   // ==========================================================================
   // Control register layout
   // ==========================================================================
   localparam int unsigned CTRL_WIDTH = 8;
   localparam int unsigned BIT_DONE = 7;
   localparam int unsigned BIT_MASTER_EN = 6;
   localparam int unsigned BIT_FAULT = 5;
   localparam int unsigned BIT_SEL_HI = 3;
   localparam int unsigned BIT_SEL_LO = 2;
   localparam int unsigned BIT_PEN = 0;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hed;

   // ==========================================================================
   // Select modes, taken from the two select mode bits
   // ==========================================================================
   localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
   localparam logic [1:0] SEL_MULTI_MASTER = 2'h1;

   // ==========================================================================
   // Link timing and framing
   // ==========================================================================
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned SCK_HALF_DEFAULT = 4;
   localparam int unsigned BUF_DEPTH_DEFAULT = 2;

   typedef enum logic [1:0] {
      SPM_LINK_IDLE = 2'b01,
      SPM_LINK_SHIFT = 2'b10
   } spm_link_state_type;

endpackage : spm_pkg

// ### testbench/spm_master_monitor.sv
// Concurrent checks on the ports of the serial port master.
`timescale 1ns/100ps
`default_nettype none
module spm_master_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic [7:0] ctrl_rdata,
   input wire logic [7:0] data_rdata,
   input wire logic int_enable,
   input wire logic irq,
   input wire logic sck_o,
   input wire logic select_pin_i,
   input wire logic select_pin_o,
   input wire logic select_pin_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Checks
   chk_irq_cause: assert property (irq == ($past(int_enable) && (ctrl_rdata[7] || ctrl_rdata[5])))
      else $error("irq does not follow the flags");
   chk_sck_still: assert property ((!ctrl_rdata[6] || !ctrl_rdata[0]) [*4] |-> !sck_o)
      else $error("sck moves while disabled");
   chk_fault_set: assert property (($fell(select_pin_i) && ctrl_rdata[6] && ctrl_rdata[3:2] == 2'h1)
      ##1 (!select_pin_i) [*3] |-> ##[0:2] (ctrl_rdata[5] && !ctrl_rdata[6] && !ctrl_rdata[0]))
      else $error("mode fault not taken");
   chk_no_reenable: assert property (!$past(ctrl_wr) && !$past(ctrl_rdata[6]) |-> !ctrl_rdata[6])
      else $error("master enable set by itself");
   chk_ctrl_write: assert property (ctrl_wr |=> ctrl_rdata[4:1] == {1'b0, $past(ctrl_wdata[3:2]), 1'b0})
      else $error("control write not stored");
   chk_rx_with_done: assert property (!$stable(data_rdata) |-> ctrl_rdata[7])
      else $error("receive data without done flag");
   chk_sel_level: assert property ($stable(ctrl_rdata[3:2]) |-> select_pin_o == (ctrl_rdata[3] && ctrl_rdata[2]))
      else $error("select output level wrong");
   chk_sel_drive: assert property ($stable(ctrl_rdata[3]) |-> select_pin_oe == ctrl_rdata[3])
      else $error("select drive wrong");
endmodule : spm_master_monitor
bind spm_master spm_master_monitor spm_master_monitor_i (.clk, .rst_n, .ctrl_wr, .ctrl_wdata, .ctrl_rdata,
   .data_rdata, .int_enable, .irq, .sck_o, .select_pin_i, .select_pin_o, .select_pin_oe);
`default_nettype wire

// ### testbench/spm_slave_model.sv
// Behavioural slave device at the far end of the serial link.
`timescale 1ns/100ps
`default_nettype none
module spm_slave_model (
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   input wire logic load,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte = 8'h00
);
   logic [7:0] tx_q = 8'h00;
   int cnt = 8;
   always @(posedge load) begin
      tx_q = tx_byte;
      cnt = 0;
   end
   always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
   always @(negedge sck) cnt <= cnt + 1;
   // Once the byte is out the line is released and shows the inverse of the last bit.
   assign miso = (cnt < 8) ? tx_q[7 - cnt] : ~tx_q[0];
endmodule : spm_slave_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the serial port master.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ctrl_wr = 1'b0;
   logic data_wr = 1'b0;
   logic int_enable = 1'b0;
   logic select_pin_i = 1'b1;
   logic sl_load = 1'b0;
   logic [7:0] ctrl_wdata = 8'h00;
   logic [7:0] data_wdata = 8'h00;
   logic [7:0] sl_tx = 8'h00;
   logic [7:0] ctrl_rdata, data_rdata, sl_rx;
   logic data_wr_ready, irq, sck_o, mosi_o, miso_i, select_pin_o, select_pin_oe;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int edges = 0;
   always #25 clk = ~clk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge sck_o) edges++;
   spm_master spm_master_i (.clk, .rst_n, .link_clk, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .data_wr, .data_wdata,
      .data_wr_ready, .data_rdata, .int_enable, .irq, .sck_o, .mosi_o, .miso_i, .select_pin_i, .select_pin_o,
      .select_pin_oe);
   // The slave is selected all the time, as a general-purpose pin of the system would select it.
   spm_slave_model spm_slave_model_i (.sck(sck_o), .mosi(mosi_o), .miso(miso_i), .load(sl_load), .tx_byte(sl_tx),
      .rx_byte(sl_rx));
   // ==========
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask : ticks
   task automatic cw(input logic [7:0] v);
      @(negedge clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = v;
      @(negedge clk);
      ctrl_wr = 1'b0;
   endtask : cw
   task automatic dw(input logic [7:0] v);
      @(negedge clk);
      data_wr = 1'b1;
      data_wdata = v;
      @(negedge clk);
      data_wr = 1'b0;
   endtask : dw
   task automatic load_slave(input logic [7:0] v);
      sl_tx = v;
      sl_load = 1'b1;
      #1 sl_load = 1'b0;
   endtask : load_slave
   // Waits until the running count of SCK pulses reaches the given total (at most 400 cycles), then lets the done flag cross back.
   task automatic wait_edges(input int target);
      for (int n = 0; n < 400 && edges < target; n++) @(negedge clk);
      ticks(10);
   endtask : wait_edges
   // ==========
   // Scenarios
   task automatic t_modes;
      check("ctrl reset", ctrl_rdata, 8'h04);
      check("pins reset", {3'h0, data_wr_ready, select_pin_oe, select_pin_o, irq, sck_o}, 8'h10);
      cw(8'hed);
      ticks(1);
      check("ctrl", ctrl_rdata, 8'hed);
      check("four wire high", {6'h0, select_pin_oe, select_pin_o}, 8'h03);
      cw(8'he9);
      ticks(1);
      check("four wire low", {6'h0, select_pin_oe, select_pin_o}, 8'h02);
      cw(8'h41);
      ticks(1);
      check("three wire", {6'h0, select_pin_oe, select_pin_o}, 8'h00);
   endtask : t_modes
   task automatic t_xfer;
      int base;
      int_enable = 1'b1;
      load_slave(8'h3c);
      base = edges;
      dw(8'ha5);
      wait_edges(base + 8);
      check("done", {7'h0, ctrl_rdata[7]}, 8'h01);
      check("rx", data_rdata, 8'h3c);
      check("tx", sl_rx, 8'ha5);
      check("irq", {7'h0, irq}, 8'h01);
      cw(8'h41);
      ticks(2);
      check("irq off", {7'h0, irq}, 8'h00);
      int_enable = 1'b0;
   endtask : t_xfer
   task automatic t_hold;
      int base;
      cw(8'h01);
      dw(8'h11);
      cw(8'h40);
      load_slave(8'hc3);
      base = edges;
      dw(8'h22);
      ticks(30);
      check("held", 8'(edges - base), 8'h00);
      cw(8'h41);
      wait_edges(base + 8);
      ticks(30);
      check("one byte", 8'(edges - base), 8'h08);
      check("rx", data_rdata, 8'hc3);
      check("tx", sl_rx, 8'h22);
   endtask : t_hold
   task automatic t_fill;
      int base;
      int k;
      logic full;
      k = 0;
      full = 1'b0;
      base = edges;
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         data_wr = data_wr_ready;
         data_wdata = 8'h60 + 8'(k);
         if (data_wr_ready !== 1'b1) full = 1'b1;
         else k++;
      end
      @(negedge clk);
      data_wr = 1'b0;
      wait_edges(base + 8 * k);
      check("full", {7'h0, full}, 8'h01);
      check("all sent", 8'(edges - base), 8'(8 * k));
      check("last", sl_rx, 8'h5f + 8'(k));
   endtask : t_fill
   task automatic t_fault;
      int_enable = 1'b1;
      select_pin_i = 1'b0;
      ticks(5);
      check("no fault three wire", ctrl_rdata, 8'hc1);
      select_pin_i = 1'b1;
      ticks(3);
      cw(8'h45);
      select_pin_i = 1'b0;
      ticks(5);
      check("fault", ctrl_rdata, 8'h24);
      check("fault irq", {7'h0, irq}, 8'h01);
      ticks(20);
      check("stays off", ctrl_rdata, 8'h24);
      select_pin_i = 1'b1;
      int_enable = 1'b0;
      ticks(3);
      cw(8'h45);
      ticks(1);
      check("again", ctrl_rdata, 8'h45);
   endtask : t_fault
   initial begin
      ticks(2);
      rst_n = 1'b1;
      ticks(10);
      t_modes;
      t_xfer;
      t_hold;
      t_fill;
      t_fault;
      stop_test;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         stop_test;
      end
   end
endmodule : tb
`default_nettype wire
